// ==== core/pipeline_fault_control.sv ====
/*
 * Pipeline fault controller: stalls, slips, precise exceptions, bypass steering.
 * Assumes the datapath presents each instruction leaving IF with its decode
 * attributes, and reports cache, translation and exception conditions on the
 * same clock; it follows freeze_o, slip_o and redirect_o one cycle later.
 */
`default_nettype none
module pipeline_fault_control #(
    parameter int unsigned PC_W = 32
) (
    input  wire logic                                ref_clk_i,
    input  wire logic                                reset_i,
    input  wire logic                                if_valid_i,
    input  wire logic [PC_W-1:0]                     if_pc_i,
    input  wire logic [4:0]                          if_rs_i,
    input  wire logic [4:0]                          if_rt_i,
    input  wire logic [4:0]                          if_rd_i,
    input  wire logic                                if_we_i,
    input  wire logic [fault_ctl_pkg::ATTR_W-1:0]    if_attr_i,
    input  wire logic                                fetch_address_error_i,
    input  wire logic [fault_ctl_pkg::RFE_W-1:0]     rf_exc_i,
    input  wire logic [fault_ctl_pkg::EXE_W-1:0]     ex_exc_i,
    input  wire logic [fault_ctl_pkg::DCE_W-1:0]     dc_exc_i,
    input  wire logic                                instr_translation_miss_i,
    input  wire logic                                instr_cache_miss_i,
    input  wire logic                                data_translation_miss_i,
    input  wire logic                                data_cache_miss_i,
    input  wire logic                                data_cache_busy_i,
    input  wire logic                                victim_dirty_i,
    input  wire logic                                refill_last_i,
    input  wire logic                                cacheop_done_i,
    input  wire logic                                muldiv_busy_i,
    input  wire logic                                nullify_rf_i,
    input  wire logic [fault_ctl_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [31:0]                         reg_wdata_i,
    input  wire logic                                reg_wr_i,
    input  wire logic                                reg_rd_i,
    output logic [31:0]                              reg_rdata_o,
    output logic                                     freeze_o,
    output logic                                     slip_o,
    output logic                                     wbuf_push_o,
    output logic                                     redirect_o,
    output logic [fault_ctl_pkg::CODE_W-1:0]         exc_code_o,
    output logic [PC_W-1:0]                          exception_return_pc_o,
    output logic                                     exl_o,
    output logic [fault_ctl_pkg::NSTG-1:0]           stage_valid_o,
    output logic [4:0]                               rf_rs_o,
    output logic [4:0]                               rf_rt_o,
    output logic [4:0]                               rf_wr_addr_o,
    output logic                                     rf_we_o,
    output logic [1:0]                               byp_rs_sel_o,
    output logic [1:0]                               byp_rt_sel_o
);
    typedef enum {MISS_IDLE, MISS_EVICT, MISS_REFILL} miss_state_t;

    localparam int unsigned N = fault_ctl_pkg::NSTG;

    // ********************************************************************
    // Stage state
    // ********************************************************************
    logic [N-1:0]                      val_r;
    logic [N-1:0]                      exc_r;
    logic [4:0]                        code_r [N];
    logic [PC_W-1:0]                   pc_r   [N];
    logic [4:0]                        dst_r  [N];
    logic [N-1:0]                      we_r;
    logic [fault_ctl_pkg::ATTR_W-1:0]  attr_r [N];
    miss_state_t                       miss_r;
    logic [N-1:0]                      act;
    logic [N-1:0]                      nx_e;
    logic [N-1:0]                      kill;
    logic [4:0]                        nx_code [N];
    logic                              commit;
    logic                              rf_stall;
    logic                              dc_stall;
    logic                              miss_start;
    logic                              stall;
    logic                              rf_live;
    logic                              load_data_slip;
    logic                              muldiv_busy_slip;
    logic                              store_load_slip;
    logic                              cpi;
    logic                              slip;
    logic [4:0]                        dst_src_rs;
    logic [4:0]                        dst_src_rt;
    logic                              cause_bd_r;

    function automatic logic [4:0] first_bit(input logic [8:0] v);
        first_bit = 5'h00;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) begin
                first_bit = 5'(i);
            end
        end
    endfunction : first_bit

    // ********************************************************************
    // Fault detection
    // ********************************************************************
    assign act = val_r & ~exc_r;
    assign commit = val_r[fault_ctl_pkg::S_WB] & exc_r[fault_ctl_pkg::S_WB];
    assign nx_e[0] = act[0] & (|rf_exc_i);
    assign nx_e[1] = act[1] & (|ex_exc_i);
    assign nx_e[2] = act[2] & (|dc_exc_i);
    assign nx_e[3] = 1'b0;
    assign nx_code[0] = fault_ctl_pkg::CODE_RF_BASE + first_bit(9'(rf_exc_i));
    assign nx_code[1] = fault_ctl_pkg::CODE_EX_BASE + first_bit(9'(ex_exc_i));
    assign nx_code[2] = fault_ctl_pkg::CODE_DC_BASE + first_bit(9'(dc_exc_i));
    assign nx_code[3] = fault_ctl_pkg::CODE_FETCH;
    // Any older stage raising a fault kills everything younger
    assign kill[3] = 1'b0;
    assign kill[2] = 1'b0;
    assign kill[1] = nx_e[2];
    assign kill[0] = nx_e[2] | nx_e[1];

    // A faulting or killed RF/DC instruction raises no new stall; nullify_rf_i does not gate rf_stall
    assign rf_stall = act[0] & ~nx_e[0] & ~kill[0]
                    & (instr_translation_miss_i | instr_cache_miss_i);
    assign miss_start = (miss_r == MISS_IDLE) & act[2] & ~nx_e[2] & data_cache_miss_i;
    assign dc_stall = (miss_r != MISS_IDLE) | miss_start
                    | (act[2] & ~nx_e[2] & (data_translation_miss_i
                    | data_cache_busy_i))
                    | (act[2] & ~nx_e[2] & attr_r[2][fault_ctl_pkg::A_CACHEOP]
                    & ~cacheop_done_i);
    assign stall = ~commit & (rf_stall | dc_stall);

    // ********************************************************************
    // Issue check on the instruction in RF
    // ********************************************************************
    assign rf_live = act[0] & ~nx_e[0] & ~kill[0] & ~nullify_rf_i;
    assign load_data_slip = rf_live & act[1] & we_r[1] & attr_r[1][fault_ctl_pkg::A_LATE]
               & (dst_r[1] != fault_ctl_pkg::REG_ZERO)
               & ((dst_r[1] == dst_src_rs) | (dst_r[1] == dst_src_rt));
    assign muldiv_busy_slip = rf_live & attr_r[0][fault_ctl_pkg::A_MFHL] & muldiv_busy_i;
    assign store_load_slip = rf_live & act[1] & attr_r[1][fault_ctl_pkg::A_STORE]
               & (attr_r[0][fault_ctl_pkg::A_LOAD]
               | attr_r[0][fault_ctl_pkg::A_STORE]);
    assign cpi = rf_live & act[1] & attr_r[1][fault_ctl_pkg::A_MTCFG];
    assign slip = ~commit & ~stall & (load_data_slip | muldiv_busy_slip | store_load_slip | cpi);

    // Source fields of the RF instruction double as register file addresses
    assign dst_src_rs = rf_rs_o;
    assign dst_src_rt = rf_rt_o;

    // ********************************************************************
    // Pipeline advance
    // ********************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || commit) begin
            val_r <= '0;
            exc_r <= '0;
        end else if (!stall) begin
            val_r[3] <= val_r[2];
            exc_r[3] <= exc_r[2] | nx_e[2];
            val_r[2] <= val_r[1] & ~kill[1];
            exc_r[2] <= (exc_r[1] | nx_e[1]) & ~kill[1];
            if (slip) begin
                val_r[1] <= 1'b0;
                exc_r[1] <= 1'b0;
            end else begin
                val_r[1] <= val_r[0] & ~kill[0] & ~nullify_rf_i;
                exc_r[1] <= (exc_r[0] | nx_e[0]) & ~kill[0] & ~nullify_rf_i;
                // An RF fault also cancels the younger instruction leaving IF
                val_r[0] <= if_valid_i & ~(|kill) & ~nx_e[0];
                exc_r[0] <= fetch_address_error_i & ~(|kill);
            end
        end
    end

    // Payload travels with the valid bits; codes of flagged instructions stick
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < N; i++) begin
                code_r[i] <= fault_ctl_pkg::CODE_FETCH;
                pc_r[i]   <= '0;
                dst_r[i]  <= fault_ctl_pkg::REG_ZERO;
                attr_r[i] <= '0;
            end
            we_r <= '0;
        end else if (!stall) begin
            for (int i = 3; i > 0; i--) begin
                if (i > 1 || !slip) begin
                    code_r[i] <= exc_r[i-1] ? code_r[i-1] : nx_code[i-1];
                    pc_r[i]   <= pc_r[i-1];
                    dst_r[i]  <= dst_r[i-1];
                    we_r[i]   <= we_r[i-1];
                    attr_r[i] <= attr_r[i-1];
                end
            end
            if (!slip) begin
                code_r[0] <= fault_ctl_pkg::CODE_FETCH;
                pc_r[0]   <= if_pc_i;
                dst_r[0]  <= if_rd_i;
                we_r[0]   <= if_we_i;
                attr_r[0] <= if_attr_i;
            end
        end
    end

    // ********************************************************************
    // Data cache miss with dirty victim
    // ********************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            miss_r <= MISS_IDLE;
        end else begin
            case (miss_r)
                MISS_IDLE: begin
                    if (miss_start && !commit) begin
                        miss_r <= victim_dirty_i ? MISS_EVICT : MISS_REFILL;
                    end
                end
                MISS_EVICT:  miss_r <= MISS_REFILL;
                MISS_REFILL: begin
                    if (refill_last_i) begin
                        miss_r <= MISS_IDLE;
                    end
                end
                default:     miss_r <= MISS_IDLE;
            endcase
        end
    end

    // ********************************************************************
    // Register addresses and bypass steering
    // ********************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rf_rs_o      <= fault_ctl_pkg::REG_ZERO;
            rf_rt_o      <= fault_ctl_pkg::REG_ZERO;
            rf_wr_addr_o <= fault_ctl_pkg::REG_ZERO;
            rf_we_o      <= 1'b0;
            byp_rs_sel_o <= fault_ctl_pkg::BYP_REGFILE;
            byp_rt_sel_o <= fault_ctl_pkg::BYP_REGFILE;
        end else begin
            // A held WB entry has already written; never write it twice
            rf_we_o <= ~commit & ~stall & val_r[2] & ~exc_r[2] & ~nx_e[2] & we_r[2];
            if (!stall) begin
                rf_wr_addr_o <= dst_r[2];
            end
            if (!stall && !slip) begin
                rf_rs_o <= if_rs_i;
                rf_rt_o <= if_rt_i;
                byp_rs_sel_o <= byp_pick(rf_rs_o);
                byp_rt_sel_o <= byp_pick(rf_rt_o);
            end else if (slip) begin
                byp_rs_sel_o <= fault_ctl_pkg::BYP_REGFILE;
                byp_rt_sel_o <= fault_ctl_pkg::BYP_REGFILE;
            end
        end
    end

    // Nearest producer wins; the EX instruction lands in DC, DC lands in WB
    function automatic logic [1:0] byp_pick(input logic [4:0] src);
        byp_pick = fault_ctl_pkg::BYP_REGFILE;
        if (src != fault_ctl_pkg::REG_ZERO) begin
            if (act[2] && we_r[2] && dst_r[2] == src) begin
                byp_pick = fault_ctl_pkg::BYP_WB;
            end
            if (act[1] && we_r[1] && dst_r[1] == src) begin
                byp_pick = fault_ctl_pkg::BYP_DC;
            end
        end
    endfunction : byp_pick

    // ********************************************************************
    // Exception commit and register port
    // ********************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            exception_return_pc_o <= '0;
            exc_code_o <= fault_ctl_pkg::CODE_FETCH;
            exl_o      <= 1'b0;
            redirect_o <= 1'b0;
            cause_bd_r <= 1'b0;
        end else begin
            redirect_o <= commit;
            if (commit) begin
                exception_return_pc_o <= pc_r[3];
                exc_code_o <= code_r[3];
                cause_bd_r <= attr_r[3][fault_ctl_pkg::A_BD];
                exl_o      <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == fault_ctl_pkg::REG_STATUS) begin
                exl_o <= reg_wdata_i[fault_ctl_pkg::STATUS_EXL_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_rdata_o   <= '0;
            freeze_o      <= 1'b0;
            slip_o        <= 1'b0;
            wbuf_push_o   <= 1'b0;
            stage_valid_o <= '0;
        end else begin
            freeze_o      <= stall;
            slip_o        <= slip;
            wbuf_push_o   <= miss_start & victim_dirty_i & ~commit;
            stage_valid_o <= val_r;
            reg_rdata_o   <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    fault_ctl_pkg::REG_EXC_PC: reg_rdata_o <= 32'(exception_return_pc_o);
                    fault_ctl_pkg::REG_CAUSE: begin
                        reg_rdata_o[fault_ctl_pkg::CAUSE_BD_BIT] <= cause_bd_r;
                        reg_rdata_o[fault_ctl_pkg::CAUSE_CODE_LSB +: 5] <= exc_code_o;
                    end
                    fault_ctl_pkg::REG_STATUS:
                        reg_rdata_o[fault_ctl_pkg::STATUS_EXL_BIT] <= exl_o;
                    default:   reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_freeze_holds;
        @(posedge ref_clk_i) disable iff (reset_i) stall |=> (val_r == $past(val_r));
    endproperty
    a_freeze_holds: assert property (p_freeze_holds) else $error("stall moved pipe");
    property p_slip_bubble;
        @(posedge ref_clk_i) disable iff (reset_i)
            slip |=> !val_r[1] && val_r[3] == $past(val_r[2]) && freeze_o == 1'b0;
    endproperty
    a_slip_bubble: assert property (p_slip_bubble) else $error("slip not bubbled");
    property p_commit_flush;
        @(posedge ref_clk_i) disable iff (reset_i) commit |=> val_r == '0 && redirect_o;
    endproperty
    a_commit_flush: assert property (p_commit_flush) else $error("no flush");
    property p_commit_record;
        @(posedge ref_clk_i) disable iff (reset_i)
            commit |=> exception_return_pc_o == $past(pc_r[3]) && exl_o
                    && exc_code_o == $past(code_r[3]);
    endproperty
    a_commit_record: assert property (p_commit_record) else $error("bad record");
    property p_kill_younger;
        @(posedge ref_clk_i) disable iff (reset_i)
            nx_e[1] && !stall && !commit && !slip |=> !val_r[1];
    endproperty
    a_kill_younger: assert property (p_kill_younger) else $error("younger survived");
    property p_no_slip_killed;
        @(posedge ref_clk_i) disable iff (reset_i) slip |-> act[0] && !nullify_rf_i;
    endproperty
    a_no_slip_killed: assert property (p_no_slip_killed) else $error("killed slipped");
    property p_sli_once;
        @(posedge ref_clk_i) disable iff (reset_i)
            store_load_slip && slip && !load_data_slip && !muldiv_busy_slip && !cpi ##1 !stall && !commit |-> !store_load_slip;
    endproperty
    a_sli_once: assert property (p_sli_once) else $error("store slip too long");
    property p_evict;
        @(posedge ref_clk_i) disable iff (reset_i)
            miss_start && victim_dirty_i && !commit |=> wbuf_push_o && miss_r == MISS_EVICT
                ##1 miss_r == MISS_REFILL && stall;
    endproperty
    a_evict: assert property (p_evict) else $error("dirty victim lost");
    c_commit: cover property (@(posedge ref_clk_i) disable iff (reset_i) commit);
    c_ldi: cover property (@(posedge ref_clk_i) disable iff (reset_i) load_data_slip && slip);
    c_evict: cover property (@(posedge ref_clk_i) disable iff (reset_i) miss_r == MISS_EVICT);
endmodule : pipeline_fault_control
`default_nettype wire

// ==== include/fault_ctl_pkg.sv ====
/*
 * Shared constants for the pipeline fault controller.
 * Assumes a five-stage in-order pipeline whose IF stage lives in the datapath.
 */
`default_nettype none
package fault_ctl_pkg;
    // Stage indices of the tracked stages
    localparam int unsigned NSTG = 4;
    localparam int unsigned S_RF = 0;
    localparam int unsigned S_EX = 1;
    localparam int unsigned S_DC = 2;
    localparam int unsigned S_WB = 3;
    // Instruction attribute bits supplied with each fetched instruction
    localparam int unsigned ATTR_W    = 7;
    localparam int unsigned A_LOAD    = 0;
    localparam int unsigned A_STORE   = 1;
    localparam int unsigned A_LATE    = 2;
    localparam int unsigned A_MFHL    = 3;
    localparam int unsigned A_MTCFG   = 4;
    localparam int unsigned A_CACHEOP = 5;
    localparam int unsigned A_BD      = 6;
    // Exception source widths per stage
    localparam int unsigned RFE_W  = 9;
    localparam int unsigned EXE_W  = 3;
    localparam int unsigned DCE_W  = 6;
    localparam int unsigned CODE_W = 5;
    localparam logic [4:0] CODE_FETCH   = 5'h00;
    localparam logic [4:0] CODE_RF_BASE = 5'h01;
    localparam logic [4:0] CODE_EX_BASE = 5'h0a;
    localparam logic [4:0] CODE_DC_BASE = 5'h0d;
    // Register port map
    localparam int unsigned ADDR_W = 2;
    localparam logic [1:0] REG_EXC_PC = 2'h0;
    localparam logic [1:0] REG_CAUSE  = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam int unsigned CAUSE_BD_BIT   = 31;
    localparam int unsigned CAUSE_CODE_LSB = 2;
    localparam int unsigned STATUS_EXL_BIT = 1;
    // Bypass selects for the EX operand muxes
    localparam logic [1:0] BYP_REGFILE = 2'h0;
    localparam logic [1:0] BYP_DC      = 2'h1;
    localparam logic [1:0] BYP_WB      = 2'h2;
    localparam logic [4:0] REG_ZERO    = 5'h00;
endpackage : fault_ctl_pkg
`default_nettype wire

// ==== tb/datapath_model.sv ====
/* Far-side model: instruction stream leaving fetch and a slow data refill.
   Assumes freeze_o from the fault controller holds fetch and starts refill. */
`default_nettype none
module datapath_model (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        freeze_o,
    output logic             if_valid_i,
    output logic [31:0]      if_pc_i,
    output logic             refill_last_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    // Refill ends four cycles into a freeze, so the stall is seen to last
    always_ff @(posedge ref_clk_i) begin
        if_valid_i    <= !reset_i;
        if_pc_i       <= reset_i ? 32'h0 : (freeze_o ? if_pc_i : if_pc_i + 32'h4);
        refill_last_i <= !reset_i && cnt_r == 2'h3;
        cnt_r         <= (reset_i || !freeze_o) ? 2'h0 : cnt_r + 2'h1;
    end
endmodule : datapath_model
`default_nettype wire

// ==== tb/pipeline_fault_control_tb_top.sv ====
/* Self-checking bench for the pipeline fault controller.
   Assumes the datapath model supplies fetch traffic and refill. */
`default_nettype none
module pipeline_fault_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 0, reset_i = 1, if_we_i, fetch_address_error_i, data_cache_miss_i;
    logic victim_dirty_i, muldiv_busy_i, nullify_rf_i, reg_wr_i, reg_rd_i, if_valid_i;
    logic refill_last_i, freeze_o, slip_o, wbuf_push_o, redirect_o, exl_o, rf_we_o;
    logic instr_translation_miss_i = 0, instr_cache_miss_i = 0, data_translation_miss_i = 0;
    logic data_cache_busy_i = 0, cacheop_done_i = 1;
    logic [4:0]  if_rs_i, if_rt_i, if_rd_i, rf_rs_o, rf_rt_o, rf_wr_addr_o, exc_code_o;
    logic [fault_ctl_pkg::ATTR_W-1:0] if_attr_i;
    logic [8:0]  rf_exc_i;
    logic [2:0]  ex_exc_i;
    logic [5:0]  dc_exc_i;
    logic [31:0] if_pc_i, reg_wdata_i, reg_rdata_o, exception_return_pc_o, d;
    logic [1:0]  reg_addr_i, byp_rs_sel_o, byp_rt_sel_o;
    logic [3:0]  stage_valid_o;
    int          fails = 0, num_checks = 0;
    pipeline_fault_control uut (.*);
    datapath_model far (.*);
    always #5 ref_clk_i = !ref_clk_i;
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: output mismatch", $time);
        end
    endtask : chk
    task automatic results;
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc
    task automatic rd(input logic [1:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        cyc(1);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    // Bounded wait; running out ends the run as a failure
    task automatic wait_for(ref logic s);
        int i;
        for (i = 0; i < 20; i++) begin
            cyc(1);
            #1 if (s === 1'b1) break;
        end
        if (i == 20) begin
            fails++;
            results();
        end
    endtask : wait_for
    task automatic s_slip;
        if_attr_i <= 7'h05;
        if_rd_i <= 5'h07;
        if_we_i <= 1'b1;
        cyc(1);
        if_attr_i <= '0;
        if_we_i <= 1'b0;
        if_rs_i <= 5'h07;
        cyc(1);
        if_rs_i <= '0;
        wait_for(slip_o);
        cyc(1);
        #1 chk(byp_rs_sel_o === fault_ctl_pkg::BYP_WB && slip_o === 1'b0);
    endtask : s_slip
    task automatic s_exc;
        cyc(6);
        ex_exc_i <= 3'h2;
        rf_exc_i <= 9'h020;
        cyc(1);
        ex_exc_i <= '0;
        rf_exc_i <= '0;
        wait_for(redirect_o);
        chk(exc_code_o === fault_ctl_pkg::CODE_EX_BASE + 5'h1 && exl_o === 1'b1);
        repeat (4) begin
            cyc(1);
            #1 chk(redirect_o === 1'b0);
        end
        rd(fault_ctl_pkg::REG_CAUSE);
        chk(d[6:2] === 5'h0b);
    endtask : s_exc
    task automatic s_dirty;
        cyc(6);
        data_cache_miss_i <= 1'b1;
        victim_dirty_i <= 1'b1;
        cyc(1);
        #1 chk(wbuf_push_o === 1'b1 && freeze_o === 1'b1);
        wait_for(refill_last_i);
        chk(freeze_o === 1'b1 && wbuf_push_o === 1'b0);
        data_cache_miss_i <= 1'b0;
        victim_dirty_i <= 1'b0;
        cyc(2);
        #1 chk(freeze_o === 1'b0);
    endtask : s_dirty
    initial begin
        {if_we_i, fetch_address_error_i, data_cache_miss_i, victim_dirty_i, muldiv_busy_i} = '0;
        {nullify_rf_i, reg_wr_i, reg_rd_i, if_rs_i, if_rt_i, if_rd_i, if_attr_i} = '0;
        {rf_exc_i, ex_exc_i, dc_exc_i, reg_addr_i, reg_wdata_i} = '0;
        cyc(5);
        reset_i <= 1'b0;
        #1 chk(freeze_o === 1'b0 && redirect_o === 1'b0 && exl_o === 1'b0);
        cyc(3);
        s_slip();
        s_exc();
        s_dirty();
        results();
    end
endmodule : pipeline_fault_control_tb_top
`default_nettype wire
